// File: exec_defs.svh
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

// apb byte offsets
`define OFF_INSTR 12'h000
`define OFF_WREG 12'h004
`define OFF_STATUS 12'h008
`define OFF_BANK 12'h00C
`define OFF_POWER 12'h010

// arithmetic flag positions in the status register
`define ST_CARRY 0
`define ST_NIBBLE 1
`define ST_ZERO 2
`define ST_RANGE 3
`define ST_NEG 4

// power register field positions
`define PW_TIMEOUT_N 0
`define PW_POWERDOWN_N 1
`define PW_SLEEPING 2
`define PW_BUSY 3
`define PW_ILLEGAL 4

// reset values
`define RST_WREG 8'h00
`define RST_STATUS 5'h00
`define RST_BANK 4'h0

// opcode patterns
`define OPC_FILL 7'h34
`define OPC_SLEEP 16'h0003
`define OPC_ACC_MINUS_REG_BORROW 6'h15
`define OPC_LITERAL_MINUS_ACC 8'h08
`define OPC_REG_MINUS_ACC 6'h17

// access bank: low half maps to bank 0, high half to the top bank
`define ACCESS_LOW_BANK 4'h0
`define ACCESS_HIGH_BANK 4'hF
`define FILL_VALUE 8'hFF

`endif

// File: exec_pkg.sv
package exec_pkg;

  // one instruction cycle, one-hot
  typedef enum logic [4:0] {
    PH_IDLE = 5'h01,
    PH_Q1 = 5'h02,
    PH_Q2 = 5'h04,
    PH_Q3 = 5'h08,
    PH_Q4 = 5'h10
  } phase_e;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_FILL = 3'h1,
    OP_SLEEP = 3'h2,
    OP_ACC_MINUS_REG_BORROW = 3'h3,
    OP_LITERAL_MINUS_ACC = 3'h4,
    OP_REG_MINUS_ACC = 3'h5
  } op_e;

endpackage

// File: sub8_alu.sv
`timescale 1ns/1ps
`default_nettype none

// minuend - subtrahend - !carry_in, carry out means no borrow
module sub8_alu (
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic carry_out,
  output logic nibble_carry,
  output logic zero,
  output logic negative,
  output logic overflow
);

  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // two's complement: add the inverted subtrahend plus carry
  assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carry_in};
  assign low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
  assign result = full_sum[7:0];
  // set means no borrow out of each field
  assign carry_out = full_sum[8];
  assign nibble_carry = low_sum[4];
  assign zero = (full_sum[7:0] == 8'h00);
  assign negative = full_sum[7];
  // sign flips only when operands differ in sign
  assign overflow = (minuend[7] != subtrahend[7]) && (full_sum[7] != minuend[7]);

endmodule

`default_nettype wire

// File: exec_core.sv
// Contract
// - The fill instruction writes 8'hFF into the addressed register and leaves all flags alone.
// - Access-select zero uses the fixed access bank, one uses the bank pointer register.
// - The sleep instruction clears the active-low power-down flag.
// - The sleep instruction sets the active-low watchdog timeout flag.
// - The sleep instruction clears the watchdog counter and its postscaler.
// - After sleep the core halts with the oscillator stopped, entering in phase four; phase two does nothing.
// - A watchdog wake from sleep clears the timeout flag.
// - Subtract-with-borrow computes W minus register minus inverted carry.
// - Destination bit zero writes W, one writes the addressed register.
// - The three subtracts update negative, overflow, carry, nibble carry and zero.
// - Literal subtract computes literal minus W into W.
// - Literal subtract reads the literal in phase two, computes in three, writes W in four.
// - Register subtract computes register minus W and routes it by the destination bit.
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.svh"

module exec_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [11:0] rf_addr,
  output logic rf_re,
  input wire logic [7:0] rf_rdata,
  output logic rf_we,
  output logic [7:0] rf_wdata,
  output logic watchdog_clear,
  input wire logic watchdog_wake,
  input wire logic wake_req,
  output logic sleep_mode
);

  exec_pkg::phase_e phase_reg;
  exec_pkg::op_e op;
  logic [15:0] instr_reg;
  logic [7:0] w_reg;
  logic [4:0] status_reg;
  logic [3:0] bank_reg;
  logic timeout_n_reg;
  logic powerdown_n_reg;
  logic sleep_reg;
  logic illegal_reg;
  logic [11:0] rf_addr_reg;
  logic [7:0] operand_reg;
  logic [7:0] result_reg;
  logic [4:0] flags_reg;
  logic rf_we_reg;
  logic [7:0] rf_wdata_reg;
  logic watchdog_clear_reg;
  logic [31:0] prdata_reg;
  logic is_sub;
  logic dest_bit;
  logic access_sel;
  logic [7:0] reg_sel;
  logic mapped;
  logic bus_write;
  logic bus_setup;
  logic start;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic alu_cin;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_nc;
  logic alu_z;
  logic alu_n;
  logic alu_range;

  // full data-space address: bank in the top nibble, operand below
  function automatic logic [11:0] bank_addr(input logic sel, input logic [3:0] bank, input logic [7:0] f);
    logic [3:0] b;
    b = bank;
    if (!sel) begin
      b = f[7] ? `ACCESS_HIGH_BANK : `ACCESS_LOW_BANK;
    end
    return {b, f};
  endfunction

  // instruction field decode
  always_comb begin
    op = exec_pkg::OP_NONE;
    if (instr_reg[15:9] == `OPC_FILL) begin
      op = exec_pkg::OP_FILL;
    end else if (instr_reg == `OPC_SLEEP) begin
      op = exec_pkg::OP_SLEEP;
    end else if (instr_reg[15:10] == `OPC_ACC_MINUS_REG_BORROW) begin
      op = exec_pkg::OP_ACC_MINUS_REG_BORROW;
    end else if (instr_reg[15:8] == `OPC_LITERAL_MINUS_ACC) begin
      op = exec_pkg::OP_LITERAL_MINUS_ACC;
    end else if (instr_reg[15:10] == `OPC_REG_MINUS_ACC) begin
      op = exec_pkg::OP_REG_MINUS_ACC;
    end
  end

  assign is_sub = (op == exec_pkg::OP_ACC_MINUS_REG_BORROW) || (op == exec_pkg::OP_LITERAL_MINUS_ACC) ||
                  (op == exec_pkg::OP_REG_MINUS_ACC);
  assign dest_bit = instr_reg[9];
  assign access_sel = instr_reg[8];
  assign reg_sel = instr_reg[7:0];

  // apb decode; the slave always answers in the first access cycle
  assign bus_setup = psel && !penable;
  assign bus_write = psel && penable && pwrite;
  assign mapped = (paddr == `OFF_INSTR) || (paddr == `OFF_WREG) || (paddr == `OFF_STATUS) ||
                  (paddr == `OFF_BANK) || (paddr == `OFF_POWER);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;
  // a new instruction is refused while busy or asleep
  assign start = bus_write && (paddr == `OFF_INSTR) && (phase_reg == exec_pkg::PH_IDLE) && !sleep_reg;

  // read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (bus_setup) begin
      case (paddr)
        `OFF_INSTR: prdata_reg <= {16'h0000, instr_reg};
        `OFF_WREG: prdata_reg <= {24'h00_0000, w_reg};
        `OFF_STATUS: prdata_reg <= {27'h000_0000, status_reg};
        `OFF_BANK: prdata_reg <= {28'h000_0000, bank_reg};
        `OFF_POWER: prdata_reg <= {27'h000_0000, illegal_reg, (phase_reg != exec_pkg::PH_IDLE),
                                   sleep_reg, powerdown_n_reg, timeout_n_reg};
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // phase sequencer: one instruction cycle of four phases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= exec_pkg::PH_IDLE;
    end else begin
      case (phase_reg)
        exec_pkg::PH_IDLE: phase_reg <= start ? exec_pkg::PH_Q1 : exec_pkg::PH_IDLE;
        exec_pkg::PH_Q1: phase_reg <= exec_pkg::PH_Q2;
        exec_pkg::PH_Q2: phase_reg <= exec_pkg::PH_Q3;
        exec_pkg::PH_Q3: phase_reg <= exec_pkg::PH_Q4;
        exec_pkg::PH_Q4: phase_reg <= exec_pkg::PH_IDLE;
        default: phase_reg <= exec_pkg::PH_IDLE;
      endcase
    end
  end

  // instruction word and unknown-opcode marker
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_reg <= 16'h0000;
      illegal_reg <= 1'b0;
    end else if (start) begin
      instr_reg <= pwdata[15:0];
    end else if (phase_reg == exec_pkg::PH_Q1) begin
      illegal_reg <= (op == exec_pkg::OP_NONE); // unknown words pass as a no-op cycle
    end
  end

  // q1 decode fixes the address; q2 fetches the operand
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_addr_reg <= 12'h000;
      operand_reg <= 8'h00;
    end else if (phase_reg == exec_pkg::PH_Q1) begin
      rf_addr_reg <= bank_addr(access_sel, bank_reg, reg_sel);
    end else if (phase_reg == exec_pkg::PH_Q2) begin
      operand_reg <= (op == exec_pkg::OP_LITERAL_MINUS_ACC) ? reg_sel : rf_rdata;
    end
  end

  // the sleep word reads nothing in q2
  assign rf_re = (phase_reg == exec_pkg::PH_Q2) &&
                 ((is_sub && op != exec_pkg::OP_LITERAL_MINUS_ACC) || op == exec_pkg::OP_FILL);
  assign rf_addr = rf_addr_reg;

  // operand routing into the shared subtractor
  always_comb begin
    alu_a = operand_reg;
    alu_b = w_reg;
    alu_cin = 1'b1;
    if (op == exec_pkg::OP_ACC_MINUS_REG_BORROW) begin
      alu_a = w_reg;
      alu_b = operand_reg;
      alu_cin = status_reg[`ST_CARRY];
    end
  end

  sub8_alu u_sub8_alu (
    .minuend(alu_a),
    .subtrahend(alu_b),
    .carry_in(alu_cin),
    .result(alu_res),
    .carry_out(alu_c),
    .nibble_carry(alu_nc),
    .zero(alu_z),
    .negative(alu_n),
    .overflow(alu_range)
  );

  // q3 processes; the register write strobe then stands through q4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= 8'h00;
      flags_reg <= `RST_STATUS;
      rf_we_reg <= 1'b0;
      rf_wdata_reg <= 8'h00;
      watchdog_clear_reg <= 1'b0;
    end else begin
      rf_we_reg <= 1'b0;
      watchdog_clear_reg <= 1'b0;
      if (phase_reg == exec_pkg::PH_Q3) begin
        result_reg <= alu_res;
        flags_reg <= {alu_n, alu_range, alu_z, alu_nc, alu_c};
        rf_wdata_reg <= (op == exec_pkg::OP_FILL) ? `FILL_VALUE : alu_res;
        rf_we_reg <= (op == exec_pkg::OP_FILL) || (dest_bit && (op == exec_pkg::OP_ACC_MINUS_REG_BORROW ||
                     op == exec_pkg::OP_REG_MINUS_ACC));
        watchdog_clear_reg <= (op == exec_pkg::OP_SLEEP);
      end
    end
  end

  assign rf_we = rf_we_reg;
  assign rf_wdata = rf_wdata_reg;
  assign watchdog_clear = watchdog_clear_reg;

  // working register: the q4 write beats a same-cycle bus write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w_reg <= `RST_WREG;
    end else if (phase_reg == exec_pkg::PH_Q4 &&
                 (op == exec_pkg::OP_LITERAL_MINUS_ACC || (!dest_bit && is_sub))) begin
      w_reg <= result_reg;
    end else if (bus_write && paddr == `OFF_WREG) begin
      w_reg <= pwdata[7:0];
    end
  end

  // arithmetic flags; fill and sleep leave them untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= `RST_STATUS;
    end else if (phase_reg == exec_pkg::PH_Q4 && is_sub) begin
      status_reg <= flags_reg;
    end else if (bus_write && paddr == `OFF_STATUS) begin
      status_reg <= pwdata[4:0];
    end
  end

  // bank pointer register, software owned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_reg <= `RST_BANK;
    end else if (bus_write && paddr == `OFF_BANK) begin
      bank_reg <= pwdata[3:0];
    end
  end

  // power flags; hardware events win over a same-cycle software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_n_reg <= 1'b1;
      powerdown_n_reg <= 1'b1;
    end else if (phase_reg == exec_pkg::PH_Q4 && op == exec_pkg::OP_SLEEP) begin
      powerdown_n_reg <= 1'b0;
      timeout_n_reg <= 1'b1;
    end else if (sleep_reg && watchdog_wake) begin
      timeout_n_reg <= 1'b0;
    end else if (bus_write && paddr == `OFF_POWER) begin
      timeout_n_reg <= pwdata[`PW_TIMEOUT_N];
      powerdown_n_reg <= pwdata[`PW_POWERDOWN_N];
    end
  end

  // sleep is entered at the end of q4 and left on any wake source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_reg <= 1'b0;
    end else if (phase_reg == exec_pkg::PH_Q4 && op == exec_pkg::OP_SLEEP) begin
      sleep_reg <= 1'b1;
    end else if (sleep_reg && (watchdog_wake || wake_req)) begin
      sleep_reg <= 1'b0;
    end
  end

  assign sleep_mode = sleep_reg; // stops the oscillator outside this block

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cycle;
    phase_reg == exec_pkg::PH_Q1 ##1 phase_reg == exec_pkg::PH_Q2 ##1
    phase_reg == exec_pkg::PH_Q3 ##1 phase_reg == exec_pkg::PH_Q4 ##1 phase_reg == exec_pkg::PH_IDLE;
  endsequence

  sequence s_sleep_q3;
    phase_reg == exec_pkg::PH_Q3 && op == exec_pkg::OP_SLEEP;
  endsequence

  a_four_phase_cycle: assert property (start |=> s_cycle)
    else $error("instruction did not walk four phases");
  a_fill_writes_ones: assert property (phase_reg == exec_pkg::PH_Q4 && op == exec_pkg::OP_FILL
                                       |-> rf_we && rf_wdata == 8'hFF)
    else $error("fill did not write all ones");
  a_fill_flags_kept: assert property (phase_reg == exec_pkg::PH_Q4 && op == exec_pkg::OP_FILL
                                      |=> status_reg == $past(status_reg))
    else $error("fill changed the flags");
  a_access_bank_low: assert property (phase_reg == exec_pkg::PH_Q2 && !access_sel && !reg_sel[7]
                                      |-> rf_addr == {4'h0, reg_sel})
    else $error("access bank not forced");
  a_bank_pointer_used: assert property (phase_reg == exec_pkg::PH_Q2 && access_sel
                                        |-> rf_addr[11:8] == bank_reg && rf_addr[7:0] == reg_sel)
    else $error("bank pointer ignored");
  a_sleep_flags_set: assert property (s_sleep_q3 ##1 1'b1
                                      |=> !powerdown_n_reg && timeout_n_reg && sleep_reg)
    else $error("sleep flags wrong");
  a_sleep_watchdog_clear: assert property (s_sleep_q3 |=> watchdog_clear ##1 !watchdog_clear)
    else $error("watchdog clear not one pulse in q4");
  a_wake_timeout: assert property (sleep_reg && watchdog_wake |=> !timeout_n_reg && !sleep_reg)
    else $error("watchdog wake did not clear timeout");
  a_sub_dest_w: assert property (phase_reg == exec_pkg::PH_Q4 && is_sub &&
                                 (!dest_bit || op == exec_pkg::OP_LITERAL_MINUS_ACC)
                                 |=> w_reg == $past(result_reg) && !$past(rf_we))
    else $error("subtract result not routed to w");
  a_zero_flag_result: assert property (phase_reg == exec_pkg::PH_Q4 && is_sub
                                       |=> status_reg[`ST_ZERO] == ($past(result_reg) == 8'h00) &&
                                           status_reg[`ST_NEG] == ($past(result_reg) >= 8'h80))
    else $error("zero or negative flag wrong");

endmodule

`default_nettype wire

// File: exec_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.svh"

module exec_core_tb;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [11:0] rf_addr;
  logic rf_re;
  logic [7:0] rf_rdata;
  logic rf_we;
  logic [7:0] rf_wdata;
  logic watchdog_clear;
  logic watchdog_wake;
  logic wake_req;
  logic sleep_mode;
  logic [7:0] mem [0:4095];
  logic [31:0] rd;
  logic err_seen;
  int error_cnt;
  int checks_done;
  int cycles = 0;

  exec_core u_exec_core (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rf_addr(rf_addr),
    .rf_re(rf_re),
    .rf_rdata(rf_rdata),
    .rf_we(rf_we),
    .rf_wdata(rf_wdata),
    .watchdog_clear(watchdog_clear),
    .watchdog_wake(watchdog_wake),
    .wake_req(wake_req),
    .sleep_mode(sleep_mode)
  );

  // register file stand-in: read is combinational because the core samples it within the strobe cycle
  assign rf_rdata = mem[rf_addr];
  always @(posedge pclk) begin
    if (rf_we === 1'b1) begin
      mem[rf_addr] <= rf_wdata;
    end
  end

  // hang guard, far above the few hundred cycles the scenarios need
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("errors=%0d checks=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one apb transfer; the request is held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // issue one instruction and record strobes over the four phases plus the idle cycle after
  task automatic exec(input logic [15:0] ins, input logic [4:0] re_m, input logic [4:0] we_m,
                      input logic [4:0] clr_m, input logic [11:0] ra);
    logic [4:0] re_s;
    logic [4:0] we_s;
    logic [4:0] clr_s;
    logic [11:0] a_s;
    apb(1'b1, `OFF_INSTR, {16'h0000, ins});
    for (int i = 0; i < 5; i++) begin
      #1;
      re_s[i] = rf_re;
      we_s[i] = rf_we;
      clr_s[i] = watchdog_clear;
      if (i == 1) a_s = rf_addr;
      @(posedge pclk);
    end
    check(re_s, re_m);
    check(we_s, we_m);
    check(clr_s, clr_m);
    if (re_m[1]) check(a_s, ra);
  endtask

  // reference subtraction: carry and nibble carry mean no borrow
  function automatic logic [12:0] sub_exp(input logic [7:0] m, input logic [7:0] s, input logic cin);
    logic [8:0] full;
    logic [4:0] low;
    logic [4:0] st;
    full = {1'b0, m} - {1'b0, s} - {8'h00, ~cin};
    low = {1'b0, m[3:0]} - {1'b0, s[3:0]} - {4'h0, ~cin};
    st[`ST_CARRY] = ~full[8];
    st[`ST_NIBBLE] = ~low[4];
    st[`ST_ZERO] = (full[7:0] == 8'h00);
    st[`ST_RANGE] = (m[7] != s[7]) && (full[7] != m[7]);
    st[`ST_NEG] = full[7];
    return {st, full[7:0]};
  endfunction

  // kind 0 borrow subtract, 1 literal subtract, 2 register subtract
  task automatic sub_case(input int kind, input logic [15:0] ins, input logic [7:0] w0, input logic [7:0] f0,
                          input logic c0, input logic [11:0] ra);
    logic [12:0] e;
    logic dw;
    e = sub_exp((kind == 0) ? w0 : (kind == 1) ? ins[7:0] : f0, (kind == 0) ? f0 : w0, (kind == 0) ? c0 : 1'b1);
    dw = (kind == 1) || !ins[9];
    mem[ra] = f0;
    apb(1'b1, `OFF_WREG, {24'h0000_00, w0});
    apb(1'b1, `OFF_STATUS, {31'h0000_0000, c0});
    exec(ins, (kind == 1) ? 5'h00 : 5'h02, 5'h08 & {5{~dw}}, 5'h00, ra);
    apb(1'b0, `OFF_WREG, 32'h0000_0000);
    check(rd, dw ? {24'h0000_00, e[7:0]} : {24'h0000_00, w0});
    check(mem[ra], dw ? f0 : e[7:0]);
    apb(1'b0, `OFF_STATUS, 32'h0000_0000);
    check(rd, {27'h0000_000, e[12:8]});
  endtask

  task automatic t_reset();
    apb(1'b0, `OFF_POWER, 32'h0000_0000);
    check(rd, 32'h0000_0003);
    apb(1'b0, `OFF_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0000_0000);
    check({31'h0000_0000, err_seen}, 32'h0000_0001);
  endtask

  // fill keeps every flag even when all are set
  task automatic t_fill();
    apb(1'b1, `OFF_STATUS, 32'h0000_001F);
    apb(1'b1, `OFF_BANK, 32'h0000_0003);
    exec(16'h6805, 5'h02, 5'h08, 5'h00, 12'h005);
    check(mem[12'h005], 8'hFF);
    exec(16'h6910, 5'h02, 5'h08, 5'h00, 12'h310);
    check(mem[12'h310], 8'hFF);
    exec(16'h68F0, 5'h02, 5'h08, 5'h00, 12'hFF0);
    check(mem[12'hFF0], 8'hFF);
    apb(1'b0, `OFF_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_001F);
  endtask

  task automatic t_sub();
    sub_case(0, 16'h5403, 8'h05, 8'h02, 1'b1, 12'h003);
    sub_case(0, 16'h5703, 8'h02, 8'h03, 1'b1, 12'h303);
    sub_case(0, 16'h5603, 8'h02, 8'h01, 1'b0, 12'h003);
    sub_case(0, 16'h5488, 8'h80, 8'h01, 1'b1, 12'hF88);
    for (int i = 1; i < 4; i++) begin
      sub_case(1, 16'h0802, i[7:0], 8'h00, 1'b0, 12'h000);
    end
    sub_case(1, 16'h0880, 8'h01, 8'h00, 1'b0, 12'h000);
    sub_case(2, 16'h5E10, 8'h02, 8'h03, 1'b0, 12'h010);
    sub_case(2, 16'h5C10, 8'h02, 8'h02, 1'b1, 12'h010);
    sub_case(2, 16'h5D90, 8'h02, 8'h01, 1'b0, 12'h390);
  endtask

  // sleep entry, refusal of work while asleep, and both wake paths
  task automatic t_sleep();
    apb(1'b1, `OFF_POWER, 32'h0000_0002);
    exec(16'h0003, 5'h00, 5'h00, 5'h08, 12'h000);
    check(sleep_mode, 1'b1);
    apb(1'b0, `OFF_POWER, 32'h0000_0000);
    check(rd, 32'h0000_0005);
    mem[12'h007] = 8'h11;
    apb(1'b1, `OFF_INSTR, 32'h0000_6807);
    repeat (6) @(posedge pclk);
    check(mem[12'h007], 8'h11);
    watchdog_wake <= 1'b1;
    @(posedge pclk);
    watchdog_wake <= 1'b0;
    #1;
    check(sleep_mode, 1'b0);
    apb(1'b0, `OFF_POWER, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    exec(16'h0003, 5'h00, 5'h00, 5'h08, 12'h000);
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
    #1;
    check(sleep_mode, 1'b0);
    apb(1'b0, `OFF_POWER, 32'h0000_0000);
    check(rd, 32'h0000_0001);
  endtask

  // unknown word runs as a marked no-op; a word sent while busy is dropped; busy shows mid-cycle
  task automatic t_illegal();
    apb(1'b1, `OFF_INSTR, 32'h0000_FFFF);
    apb(1'b1, `OFF_INSTR, 32'h0000_6807);
    repeat (6) @(posedge pclk);
    check(mem[12'h007], 8'h11);
    apb(1'b0, `OFF_INSTR, 32'h0000_0000);
    check(rd, 32'h0000_FFFF);
    apb(1'b0, `OFF_POWER, 32'h0000_0000);
    check(rd, 32'h0000_0011);
    apb(1'b1, `OFF_INSTR, 32'h0000_6807);
    apb(1'b0, `OFF_POWER, 32'h0000_0000);
    check(rd, 32'h0000_0009);
    repeat (2) @(posedge pclk);
    check(mem[12'h007], 8'hFF);
  endtask

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    watchdog_wake = 1'b0;
    wake_req = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    for (int i = 0; i < 4096; i++) begin
      mem[i] = i[7:0] ^ 8'hA5;
    end
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_fill();
    t_sub();
    t_sleep();
    t_illegal();
    conclude();
  end
endmodule

`default_nettype wire
